// ===== logic/nsc_ctrl.sv
// Purpose: apb-driven host that issues nand command, address and data
//          cycles and decodes the status byte
// Assumes: one nand device or several on a wired ready line
// Notes:   one pin cycle at a time; refused orders set a sticky flag
//
// How it works
// - after 70h each read returns status
// - power-on busy: only ffh or 70h
// - never send unknown command codes
// - while busy only 70h, 71h, ffh
// - after 80h only 85h,10h,11h,15h,ffh
// - program pages ascending within block
// - status stays until 00h, read resumes; here any command but 70h or 71h ends it
`timescale 1ns/100ps
`default_nettype none
`include "nsc_map.svh"
module nsc_ctrl
	import nsc_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             chip_en_n,
	output logic             cmd_latch,
	output logic             addr_latch,
	output logic             write_strobe_n,
	output logic             read_strobe_n,
	output logic             write_guard_n,
	output logic      [7:0]  io_out,
	output logic             io_oe,
	input  wire logic [7:0]  io_in,
	input  wire logic        done_line_open_drain
);
	// ---------------------------------------------------------------
	// functions
	// ---------------------------------------------------------------
	function automatic logic cmd_known(input logic [7:0] c);
		case (c)
			`NSC_C_READ1, `NSC_C_COLRD, `NSC_C_PROG, `NSC_C_MPROG,
			`NSC_C_CPROG, `NSC_C_READ2, `NSC_C_CREAD, `NSC_C_CREADE,
			`NSC_C_ERASE1, `NSC_C_STATUS, `NSC_C_STATUS2,
			`NSC_C_DATAIN, `NSC_C_COLWR, `NSC_C_COPYIN, `NSC_C_ID,
			`NSC_C_ERASE2, `NSC_C_COLRD2, `NSC_C_RESET: cmd_known = 1'b1;
			default: cmd_known = 1'b0;
		endcase
	endfunction

	function automatic logic cmd_status_or_reset(input logic [7:0] c);
		cmd_status_or_reset = (c == `NSC_C_STATUS) ||
			(c == `NSC_C_STATUS2) || (c == `NSC_C_RESET);
	endfunction

	// ---------------------------------------------------------------
	// pins in, through the synchroniser
	// ---------------------------------------------------------------
	logic [8:0] pins_s;
	logic       line_ready;
	logic [7:0] io_s;

	nsc_sync3 u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.pin_in  ({done_line_open_drain, io_in}),
		.pin_out (pins_s)
	);
	// the line is wired-and over devices; low means any device busy
	assign line_ready = pins_s[8];
	assign io_s       = pins_s[7:0];

	// ---------------------------------------------------------------
	// apb slave
	// ---------------------------------------------------------------
	logic       acc;
	logic       wr_cmd;
	logic       wr_stat;
	logic [1:0] ctrl_q;
	logic       refused_q;
	logic       order_q;
	logic       init_q;
	logic       status_q;
	logic       after80_q;
	logic [7:0] byte_q;
	logic [6:0] decode_q;
	nsc_state_e state_q;

	assign acc     = psel & penable & pready;
	assign wr_cmd  = acc & pwrite & (paddr == `NSC_OFF_CMD);
	assign wr_stat = acc & pwrite & (paddr == `NSC_OFF_STAT);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= psel & penable & ~pready;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
			if (psel & penable & ~pready) begin
				case (paddr)
					`NSC_OFF_CMD: prdata <= 32'h0000_0000;
					`NSC_OFF_CTRL: prdata <= {30'h0, ctrl_q};
					`NSC_OFF_STAT: prdata <= {16'h0, byte_q, 1'b0, order_q,
						refused_q, after80_q, status_q, init_q, line_ready,
						state_q != NSC_IDLE};
					`NSC_OFF_DECODE: prdata <= {25'h0, decode_q};
					default: pslverr <= 1'b1;
				endcase
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= `NSC_CTRL_RST;
		end else if (acc & pwrite & (paddr == `NSC_OFF_CTRL)) begin
			ctrl_q <= pwdata[1:0];
		end
	end

	// ---------------------------------------------------------------
	// order legality
	// ---------------------------------------------------------------
	logic [7:0]  ob;
	nsc_kind_t   okind;
	logic        legal;
	logic [2:0]  acnt_q;
	logic [15:0] row_q;
	logic [23:0] row_full;
	logic        trk_q;
	logic [17:0] trk_blk_q;
	logic [5:0]  trk_pg_q;
	logic        order_bad;

	assign ob       = pwdata[7:0];
	assign okind    = pwdata[`NSC_CMD_KIND_LO +: 2];
	assign row_full = {ob, row_q};
	// a page at or below the last one written in the same block
	assign order_bad = after80_q && okind == NSC_K_ADDR &&
		acnt_q == `NSC_ADDR_LAST && trk_q &&
		row_full[23:6] == trk_blk_q && row_full[5:0] <= trk_pg_q;

	always_comb begin
		legal = state_q == NSC_IDLE && !order_bad;
		if (okind == NSC_K_CMD) begin
			if (!cmd_known(ob)) legal = 1'b0;
			if (!init_q && ob != `NSC_C_RESET && ob != `NSC_C_STATUS) begin
				legal = 1'b0;
			end
			if (init_q && !line_ready && !cmd_status_or_reset(ob)) begin
				legal = 1'b0;
			end
			if (after80_q && !(ob == `NSC_C_COLWR || ob == `NSC_C_PROG ||
				ob == `NSC_C_MPROG || ob == `NSC_C_CPROG ||
				ob == `NSC_C_RESET)) begin
				legal = 1'b0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			refused_q <= 1'b0;
			order_q   <= 1'b0;
		end else begin
			// a new refusal in the clearing cycle wins over the clear
			refused_q <= (refused_q & ~(wr_stat & pwdata[`NSC_ST_REFUSED]))
				| (wr_cmd & ~legal);
			order_q   <= (order_q & ~(wr_stat & pwdata[`NSC_ST_ORDER]))
				| (wr_cmd & order_bad);
		end
	end

	// power-on init ends the first time the line reads ready
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			init_q <= 1'b0;
		end else if (line_ready) begin
			init_q <= 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// command tracking
	// ---------------------------------------------------------------
	logic       take;
	nsc_op_e    op_q;
	logic       split_q;

	assign take = wr_cmd & legal;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			op_q      <= NSC_OP_NONE;
			status_q  <= 1'b0;
			after80_q <= 1'b0;
			split_q   <= 1'b0;
		end else if (take && okind == NSC_K_CMD) begin
			status_q <= ob == `NSC_C_STATUS || ob == `NSC_C_STATUS2;
			if (!cmd_status_or_reset(ob)) begin
				split_q <= ob == `NSC_C_CPROG || ob == `NSC_C_CREAD;
			end
			// any other command drops the pending program setup
			after80_q <= ob == `NSC_C_DATAIN || ob == `NSC_C_COPYIN ||
				(after80_q && ob == `NSC_C_COLWR);
			case (ob)
				`NSC_C_READ2, `NSC_C_CREAD, `NSC_C_CREADE: op_q <= NSC_OP_READ;
				`NSC_C_PROG, `NSC_C_MPROG: op_q <= NSC_OP_PROG;
				`NSC_C_CPROG: op_q <= NSC_OP_CACHE;
				`NSC_C_ERASE2: op_q <= NSC_OP_ERASE;
				// reset may cut the earlier cached page too: no result kept
				`NSC_C_RESET: op_q <= NSC_OP_NONE;
				default: op_q <= op_q;
			endcase
		end
	end

	// page order tracker; any erase confirm (d0h) restarts it, whatever the block
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acnt_q    <= 3'h0;
			row_q     <= 16'h0000;
			trk_q     <= 1'b0;
			trk_blk_q <= 18'h00000;
			trk_pg_q  <= 6'h00;
		end else if (take) begin
			if (okind == NSC_K_CMD) begin
				acnt_q <= 3'h0;
				if (ob == `NSC_C_ERASE2) trk_q <= 1'b0;
			end else if (okind == NSC_K_ADDR && after80_q) begin
				acnt_q <= acnt_q + 3'h1;
				if (acnt_q == 3'h2) row_q[7:0] <= ob;
				if (acnt_q == 3'h3) row_q[15:8] <= ob;
				if (acnt_q == `NSC_ADDR_LAST) begin
					trk_q     <= 1'b1;
					trk_blk_q <= row_full[23:6];
					trk_pg_q  <= row_full[5:0];
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// pin engine
	// ---------------------------------------------------------------
	logic [2:0] wait_q;
	logic       rd_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q        <= NSC_IDLE;
			cmd_latch      <= 1'b0;
			addr_latch     <= 1'b0;
			write_strobe_n <= 1'b1;
			read_strobe_n  <= 1'b1;
			io_out         <= 8'h00;
			io_oe          <= 1'b0;
			rd_q           <= 1'b0;
			wait_q         <= 3'h0;
		end else begin
			case (state_q)
				NSC_IDLE: if (take) begin
					cmd_latch  <= okind == NSC_K_CMD;
					addr_latch <= okind == NSC_K_ADDR;
					io_out     <= ob;
					io_oe      <= okind != NSC_K_DIN;
					rd_q       <= okind == NSC_K_DIN;
					state_q    <= NSC_SETUP;
				end
				NSC_SETUP: begin
					write_strobe_n <= rd_q;
					read_strobe_n  <= ~rd_q;
					wait_q         <= `NSC_RD_CYC;
					state_q        <= rd_q ? NSC_WAITRD : NSC_STROBE;
				end
				// device latches on the rising write strobe
				NSC_STROBE: begin
					write_strobe_n <= 1'b1;
					state_q        <= NSC_HOLD;
				end
				NSC_WAITRD: begin
					wait_q <= wait_q - 3'h1;
					if (wait_q == 3'h1) begin
						read_strobe_n <= 1'b1;
						state_q       <= NSC_HOLD;
					end
				end
				NSC_HOLD: begin
					cmd_latch  <= 1'b0;
					addr_latch <= 1'b0;
					io_oe      <= 1'b0;
					state_q    <= NSC_IDLE;
				end
				default: state_q <= NSC_IDLE;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			chip_en_n     <= 1'b1;
			write_guard_n <= 1'b0;
		end else begin
			chip_en_n     <= ~ctrl_q[`NSC_CTRL_CE];
			// guard low aborts and blocks program and erase in the device
			write_guard_n <= ~ctrl_q[`NSC_CTRL_PROT];
		end
	end

	// ---------------------------------------------------------------
	// read capture and status decode
	// ---------------------------------------------------------------
	logic cap;
	logic pe_ok;

	assign cap   = state_q == NSC_WAITRD && wait_q == 3'h1;
	assign pe_ok = op_q == NSC_OP_PROG || op_q == NSC_OP_ERASE ||
		op_q == NSC_OP_CACHE;

	// every read in status mode is a new sample of the device state;
	// status mode holds until any command other than 70h or 71h is taken
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			byte_q   <= 8'h00;
			decode_q <= 7'h00;
		end else if (cap) begin
			byte_q <= io_s;
			if (status_q) begin
				decode_q[0] <= split_q ? io_s[5] : io_s[6];
				decode_q[1] <= io_s[6];
				decode_q[2] <= io_s[7];
				// io0 is meaningful only for program or erase, once ready
				decode_q[3] <= pe_ok && (op_q == NSC_OP_CACHE ? io_s[5]
					: io_s[6]);
				decode_q[4] <= io_s[0];
				decode_q[5] <= op_q == NSC_OP_CACHE && io_s[6];
				decode_q[6] <= io_s[1];
			end
		end
	end
endmodule
`default_nettype wire

// ===== logic/nsc_map.svh
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 32-bit apb data, one aligned word per register
// Notes:   definitions only
`ifndef NSC_MAP_SVH
`define NSC_MAP_SVH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define NSC_OFF_CMD      12'h000
`define NSC_OFF_CTRL     12'h004
`define NSC_OFF_STAT     12'h008
`define NSC_OFF_DECODE   12'h00c

// ---------------------------------------------------------------
// fields
// ---------------------------------------------------------------
`define NSC_CMD_KIND_LO  8
`define NSC_CTRL_PROT    0
`define NSC_CTRL_CE      1
`define NSC_CTRL_RST     2'h0
`define NSC_ST_BUSY      0
`define NSC_ST_LINE      1
`define NSC_ST_INIT      2
`define NSC_ST_STATUS    3
`define NSC_ST_AFTER80   4
`define NSC_ST_REFUSED   5
`define NSC_ST_ORDER     6
`define NSC_ST_BYTE_LO   8

// ---------------------------------------------------------------
// command codes
// ---------------------------------------------------------------
`define NSC_C_READ1      8'h00
`define NSC_C_COLRD      8'h05
`define NSC_C_PROG       8'h10
`define NSC_C_MPROG      8'h11
`define NSC_C_CPROG      8'h15
`define NSC_C_READ2      8'h30
`define NSC_C_CREAD      8'h31
`define NSC_C_CREADE     8'h3f
`define NSC_C_ERASE1     8'h60
`define NSC_C_STATUS     8'h70
`define NSC_C_STATUS2    8'h71
`define NSC_C_DATAIN     8'h80
`define NSC_C_COLWR      8'h85
`define NSC_C_COPYIN     8'h8c
`define NSC_C_ID         8'h90
`define NSC_C_ERASE2     8'hd0
`define NSC_C_COLRD2     8'he0
`define NSC_C_RESET      8'hff

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define NSC_CLK_NS       100
`define NSC_RD_SETTLE_NS 500
`define NSC_RD_CYC       3'((`NSC_RD_SETTLE_NS + `NSC_CLK_NS - 1) / `NSC_CLK_NS)
`define NSC_ADDR_LAST    3'h4

`endif

// ===== logic/nsc_pkg.sv
// Purpose: types shared by the strobe controller
// Assumes: nothing
// Notes:   constants live in nsc_map.svh
package nsc_pkg;
	typedef enum logic [2:0] {
		NSC_IDLE,
		NSC_SETUP,
		NSC_STROBE,
		NSC_HOLD,
		NSC_WAITRD
	} nsc_state_e;

	typedef enum logic [2:0] {
		NSC_OP_NONE,
		NSC_OP_READ,
		NSC_OP_PROG,
		NSC_OP_CACHE,
		NSC_OP_ERASE
	} nsc_op_e;

	typedef logic [1:0] nsc_kind_t;
	localparam nsc_kind_t NSC_K_CMD  = 2'h0;
	localparam nsc_kind_t NSC_K_ADDR = 2'h1;
	localparam nsc_kind_t NSC_K_DOUT = 2'h2;
	localparam nsc_kind_t NSC_K_DIN  = 2'h3;
endpackage

// ===== logic/nsc_sync3.sv
// Purpose: three-flop pin synchroniser with agreement filter
// Assumes: inputs asynchronous to pclk
// Notes:   a change is taken once stages two and three agree
`timescale 1ns/100ps
`default_nettype none
module nsc_sync3 (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic [8:0] pin_in,
	output logic      [8:0] pin_out
);
	logic [8:0] s1_q;
	logic [8:0] s2_q;
	logic [8:0] s3_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_q <= 9'h000;
			s2_q <= 9'h000;
			s3_q <= 9'h000;
		end else begin
			s1_q <= pin_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_out <= 9'h000;
		end else begin
			for (int i = 0; i < 9; i++) begin
				if (s2_q[i] == s3_q[i]) begin
					pin_out[i] <= s3_q[i];
				end
			end
		end
	end
endmodule
`default_nettype wire

// ===== verif/nsc_ctrl_props.sv
// Purpose: apb and pin-cycle timing checks on nsc_ctrl
// Assumes: single pclk domain, presetn active low
// Notes:   bound to every nsc_ctrl instance
`timescale 1ns/100ps
`default_nettype none
module nsc_ctrl_props (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       psel,
	input  wire logic       penable,
	input  wire logic       pready,
	input  wire logic       pslverr,
	input  wire logic       cmd_latch,
	input  wire logic       addr_latch,
	input  wire logic       write_strobe_n,
	input  wire logic       read_strobe_n,
	input  wire logic [7:0] io_out,
	input  wire logic       io_oe
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ----------------------------------------
	// sequences
	// ----------------------------------------
	sequence s_rd_low;
		!read_strobe_n [*5] ##1 read_strobe_n;
	endsequence
	sequence s_cmd_edge;
		$rose(write_strobe_n) && cmd_latch;
	endsequence
	// ----------------------------------------
	// properties
	// ----------------------------------------
	chk_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	chk_one_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready)
		else $error("apb answer not after one wait state");
	chk_err_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	chk_wr_pulse: assert property (
		$fell(write_strobe_n) |-> io_oe ##1 write_strobe_n)
		else $error("write strobe not a driven one-cycle pulse");
	chk_rd_len: assert property ($fell(read_strobe_n) |-> s_rd_low)
		else $error("read strobe low time wrong");
	chk_rd_float: assert property (!read_strobe_n |-> !io_oe)
		else $error("io driven during read strobe");
	chk_latch_excl: assert property (!(cmd_latch && addr_latch))
		else $error("both latches high");
	chk_cmd_known: assert property (s_cmd_edge |-> io_out inside {
		8'h00, 8'h05, 8'h10, 8'h11, 8'h15, 8'h30, 8'h31, 8'h3f, 8'h60,
		8'h70, 8'h71, 8'h80, 8'h85, 8'h8c, 8'h90, 8'hd0, 8'he0, 8'hff})
		else $error("unknown command code on pins");
endmodule
bind nsc_ctrl nsc_ctrl_props u_props (.pclk, .presetn, .psel, .penable,
	.pready, .pslverr, .cmd_latch, .addr_latch, .write_strobe_n,
	.read_strobe_n, .io_out, .io_oe);
`default_nettype wire

// ===== verif/nsc_nand_model.sv
// Purpose: behavioural flash device on the far side of nsc_ctrl
// Assumes: strobe driven, no clock of its own
// Notes:   program result is what fail_prog says at the start strobe
`timescale 1ns/100ps
`default_nettype none
module nsc_nand_model #(
	parameter logic [7:0] MAKER_ID = 8'h5a, // arbitrary value
	parameter logic [1:0] DIST     = 2'h1,
	parameter int         INIT_NS  = 20000,
	parameter int         PROG_NS  = 2000
) (
	input  wire logic       chip_en_n,
	input  wire logic       cmd_latch,
	input  wire logic       write_strobe_n,
	input  wire logic       read_strobe_n,
	input  wire logic       write_guard_n,
	input  wire logic [7:0] io_drv,
	input  wire logic       fail_prog,
	output logic      [7:0] io_rd,
	output logic            line_low
);
	logic [7:0] last_cmd;
	logic       busy;
	logic       stat_mode;
	logic       fail_q;
	logic       pe_run;
	int         n_rd;
	int         gen;
	assign line_low = busy;
	task automatic go_busy(input int ns);
		int g;
		gen++;
		g = gen;
		busy = 1;
		fork
			begin
				#(ns);
				if (g == gen) busy = 0;
			end
		join_none
	endtask
	initial begin
		io_rd = 8'ha5;
		stat_mode = 0;
		fail_q = 0;
		pe_run = 0;
		gen = 0;
		last_cmd = 8'h00;
		go_busy(INIT_NS);
	end
	always @(posedge write_strobe_n) begin
		if (!chip_en_n && cmd_latch) begin
			last_cmd = io_drv;
			n_rd = 0;
			stat_mode = io_drv inside {8'h70, 8'h71};
			if (io_drv == 8'hff) begin
				pe_run = 0;
				go_busy(500);
			end
			if (io_drv inside {8'h10, 8'hd0} && write_guard_n) begin
				fail_q = fail_prog;
				pe_run = 1;
				go_busy(PROG_NS);
			end
		end
	end
	// guard low kills a running program or erase, never power-on init;
	// the guard is low through reset, so init must survive that edge
	always @(negedge write_guard_n) begin
		if (pe_run) begin
			gen++;
			busy = 0;
			pe_run = 0;
		end
	end
	// status sampled at each strobe fall, so polling sees changes
	always @(negedge read_strobe_n) begin
		if (!chip_en_n) begin
			#30;
			if (stat_mode)
				io_rd = {write_guard_n, !busy, !busy, 4'h0, fail_q};
			else if (last_cmd == 8'h90)
				io_rd = (n_rd == 4) ? {4'b0111, DIST, 2'b10} : MAKER_ID;
			else
				io_rd = 8'hc0 + 8'(n_rd);
			n_rd++;
		end
	end
	// no pull on io: released bus shows the inverse of the last byte
	always @(posedge read_strobe_n) io_rd = ~io_rd;
endmodule
`default_nettype wire

// ===== verif/tb_nsc_ctrl.sv
// Purpose: self-checking bench for nsc_ctrl against a device model
// Assumes: 10 mhz pclk, apb master with one request at a time
// Notes:   unknown command codes are drawn at random
`timescale 1ns/100ps
`default_nettype none
`include "nsc_map.svh"
module tb_nsc_ctrl;
	logic        pclk, presetn, psel, penable, pwrite, fail_prog, slv;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        pready, pslverr, ce_n, cl, al, wsn, rsn, wg_n, oe, low;
	logic [7:0]  io_out, io_rd, b;
	int          failures, n_checks;
	wire  logic       ready_line = !low;
	wire  logic [7:0] io_bus = oe ? io_out : io_rd;
	nsc_ctrl i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .chip_en_n(ce_n),
		.cmd_latch(cl), .addr_latch(al), .write_strobe_n(wsn),
		.read_strobe_n(rsn), .write_guard_n(wg_n), .io_out, .io_oe(oe),
		.io_in(io_bus), .done_line_open_drain(ready_line));
	nsc_nand_model u_nand (.chip_en_n(ce_n), .cmd_latch(cl),
		.write_strobe_n(wsn), .read_strobe_n(rsn), .write_guard_n(wg_n),
		.io_drv(io_out), .fail_prog, .io_rd, .line_low(low));
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task check(input logic [31:0] got, exp, input string m);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	task complete_run;
		$display("failures %0d checks %0d", failures, n_checks);
		if (failures == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		// no cycle count assumed: pready ends this wait, only the watchdog ends a hung one
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		slv = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task cmd(input logic [1:0] k, input logic [7:0] v);
		apb(1, `NSC_OFF_CMD, {22'h0, k, v});
		repeat (10) @(posedge pclk);
	endtask
	task stat_ref(input logic exp);
		apb(0, `NSC_OFF_STAT, 0);
		check(rd[5], exp, "refused flag");
		apb(1, `NSC_OFF_STAT, 32'h60);
	endtask
	task poll;
		cmd(0, `NSC_C_STATUS);
		for (int i = 0; i < 30; i++) begin
			cmd(3, 8'h00);
			apb(0, `NSC_OFF_STAT, 0);
			if (rd[14]) break;
		end
	endtask
	task prog(input logic [5:0] pg);
		cmd(0, `NSC_C_DATAIN);
		for (int i = 0; i < 5; i++) cmd(1, (i == 2) ? {2'b00, pg} : 8'h00);
		cmd(0, `NSC_C_PROG);
	endtask
	function automatic logic known(input logic [7:0] c);
		return c inside {8'h00, 8'h05, 8'h10, 8'h11, 8'h15, 8'h30, 8'h31,
			8'h3f, 8'h60, 8'h70, 8'h71, 8'h80, 8'h85, 8'h8c, 8'h90, 8'hd0,
			8'he0, 8'hff};
	endfunction
	// ----------------------------------------
	// clock, watchdog, sequence
	// ----------------------------------------
	initial begin
		pclk = 0;
		forever #50 pclk = ~pclk;
	end
	initial begin
		#2000000;
		failures++;
		complete_run();
	end
	initial begin
		{presetn, psel, penable, pwrite, fail_prog} = 0;
		paddr = 0;
		pwdata = 0;
		failures = 0;
		n_checks = 0;
		void'($urandom(32'h8935b4b5));
		repeat (20) @(posedge pclk);
		check(wg_n, 0, "guard in reset");
		presetn <= 1;
		apb(0, 12'h010, 0);
		check(slv, 1, "unmapped");
		apb(0, `NSC_OFF_CTRL, 0);
		check(rd, 0, "ctrl reset");
		apb(1, `NSC_OFF_CTRL, 32'h2);
		cmd(0, `NSC_C_DATAIN);
		stat_ref(1);
		cmd(0, `NSC_C_STATUS);
		stat_ref(0);
		cmd(3, 8'h00);
		apb(0, `NSC_OFF_STAT, 0);
		check(rd[14], 0, "busy at power-on");
		poll();
		check(rd[14], 1, "ready after init");
		check(rd[13], rd[14], "page buffer equals cache");
		check(rd[15], 1, "not protected");
		apb(0, `NSC_OFF_DECODE, 0);
		check(rd[3], 0, "no result before program");
		repeat (6) begin
			b = 8'($urandom);
			while (known(b)) b++;
			cmd(0, b);
			stat_ref(1);
		end
		for (int i = 0; i < 2; i++) begin
			fail_prog <= i[0];
			prog(6'(2 + i));
			cmd(0, `NSC_C_ID);
			stat_ref(1);
			poll();
			check(rd[8], i[0], "program result");
			apb(0, `NSC_OFF_DECODE, 0);
			check(rd[4], i[0], "decoded result");
			check(rd[3:1], 3'b111, "decoded ready");
			check(rd[5], 0, "no previous result");
		end
		cmd(0, `NSC_C_DATAIN);
		cmd(0, `NSC_C_ID);
		stat_ref(1);
		cmd(0, `NSC_C_RESET);
		stat_ref(0);
		prog(6'd1);
		apb(0, `NSC_OFF_STAT, 0);
		check(rd[6], 1, "page order");
		cmd(0, `NSC_C_RESET);
		apb(1, `NSC_OFF_STAT, 32'h60);
		cmd(0, `NSC_C_ID);
		cmd(1, 8'h00);
		repeat (5) cmd(3, 8'h00);
		apb(0, `NSC_OFF_STAT, 0);
		check(rd[15:8], 8'h76, "fifth id byte");
		cmd(0, `NSC_C_STATUS);
		apb(0, `NSC_OFF_STAT, 0);
		check(rd[3], 1, "status mode");
		cmd(0, `NSC_C_READ1);
		apb(0, `NSC_OFF_STAT, 0);
		check(rd[3], 0, "status mode left");
		apb(1, `NSC_OFF_CTRL, 32'h3);
		repeat (2) @(posedge pclk);
		check(wg_n, 0, "guard low");
		cmd(0, `NSC_C_STATUS);
		cmd(3, 8'h00);
		apb(0, `NSC_OFF_STAT, 0);
		check(rd[15], 0, "protected");
		complete_run();
	end
endmodule
`default_nettype wire
